// ### core/ccr_pkg.sv
// package: register map, field layout, reset values and types of the comparator control block
package ccr_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_INPUT_SELECT = 3'h2;
  localparam logic [2:0] OFS_REFERENCE = 3'h4;
  localparam logic [2:0] OFS_INT_ENABLE = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;

  // comparator_control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_HYST_LSB = 1;
  localparam int CTL_LOW_POWER_BIT = 3;
  localparam int CTL_EDGE_LSB = 4;
  localparam int CTL_PAD_EN_BIT = 6;
  localparam int CTL_RUN_STBY_BIT = 7;

  // input_select fields
  localparam int SEL_NEG_LSB = 0;
  localparam int SEL_POS_LSB = 3;
  localparam int SEL_INVERT_BIT = 7;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h9B;

  // interrupt_enable and comparator_status fields
  localparam int IEN_IRQ_BIT = 0;
  localparam int STS_FLAG_BIT = 0;
  localparam int STS_STATE_BIT = 4;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_REFERENCE = 8'hFF;
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;

  // edge mode encodings
  localparam logic [1:0] EDGE_ANY = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_RISING = 2'h3;

  // negative select code that picks the internal reference level
  localparam logic [1:0] NEG_REFERENCE = 2'h3;

  // synchronizer stages ahead of the state flop; with that flop the delay is three cycles
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CCR_ACTIVE,
    CCR_IDLE,
    CCR_STANDBY,
    CCR_POWER_DOWN
  } ccr_sleep_e;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
  } ccr_sync_s;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] input_select;
    logic [7:0] reference_level;
    logic [7:0] interrupt_enable;
    logic flag;
    logic state;
    logic [7:0] rdata;
    logic irq;
    logic event_level;
    logic pad;
    logic pad_oe;
    logic core_enable;
  } ccr_state_s;

endpackage : ccr_pkg

// ### core/ccr_sync.sv
// two-flop level synchronizer for the raw comparator output
`timescale 1ns/100ps
`default_nettype none
module ccr_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);

  ccr_pkg::ccr_sync_s q;
  ccr_pkg::ccr_sync_s next_q;

  // the first stage feeds only the second stage
  always_comb begin
    next_q = q;
    next_q.stage = {q.stage[ccr_pkg::SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.stage[ccr_pkg::SYNC_STAGES-1];

  // a single stage would let a metastable level reach the edge detector
  if (ccr_pkg::SYNC_STAGES < 2) begin : g_bad_stages
    $error("synchronizer needs at least two stages");
  end

endmodule : ccr_sync
`default_nettype wire

// ### core/ccr_comparator_control.sv
// comparator control and status registers with edge interrupt and sleep gating
// Notes on behaviour
// [RL1] flag sets on each comparator output edge of the selected kind
// [RL2] interrupt request is high while enable bit and flag are both set
// [RL3] writing one to status bit 0 clears the flag; zero leaves it
// [RL4] edge mode: 0 any edge, 1 reserved, 2 falling only, 3 rising only
// [RL5] idle sleep behaves exactly like active mode
// [RL6] standby halts the comparator unless run in standby is set
// [RL7] in standby with run in standby, flag and state are frozen
// [RL8] power-down disables comparator and pad output
// [RL9] comparator operates only while control bit 0 is one
// [RL10] control bit 6 drives the comparator output onto the pad
// [RL11] control bits 2:1 select none, small, medium or large hysteresis
// [RL12] control bit 3 puts the core in its low-current slower setting
// [RL13] input select bit 7 inverts the output before every consumer
// [RL14] input select bits 4:3 route positive pin 0 to 3
// [RL15] bits 1:0 route negative pins 0 to 2, or reference level at 3
// [RL16] reference level resets to 0xFF and drives the internal divider
// [RL17] interrupt enable bit 0 permits the interrupt request
// [RL18] status bit 4 shows the output after a three-cycle synchronizer
// [RL19] edges found by clock sampling; reserved edge mode gives no interrupt
// [RL20] reserved offsets and bits read zero and ignore writes
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ccr_comparator_control (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire ccr_pkg::ccr_sleep_e sleep_mode_in,
  input wire logic comparator_raw_in,
  output logic core_enable_out,
  output logic [1:0] hysteresis_select_out,
  output logic low_power_setting_out,
  output logic [1:0] positive_input_select_out,
  output logic [1:0] negative_input_select_out,
  output logic reference_select_out,
  output logic [7:0] reference_level_value_out,
  output logic irq_out,
  output logic event_out,
  output logic pad_out,
  output logic pad_oe_out
);

  ccr_pkg::ccr_state_s q;
  ccr_pkg::ccr_state_s next_q;

  logic sync_level;
  logic state_now;
  logic clk_live;
  logic running;
  logic rise;
  logic fall;
  logic edge_hit;
  logic flag_clear;
  logic [1:0] edge_mode;
  logic [1:0] neg_sel;

  ccr_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(comparator_raw_in),
    .sync_out(sync_level)
  );

  always_comb begin
    next_q = q;
    edge_mode = q.control[ccr_pkg::CTL_EDGE_LSB +: 2];
    // peripheral clock stops in standby, so sampled status must hold still there
    clk_live = (sleep_mode_in != ccr_pkg::CCR_STANDBY); // RL5 RL7
    running = q.control[ccr_pkg::CTL_ENABLE_BIT] // RL9
      && (sleep_mode_in != ccr_pkg::CCR_POWER_DOWN) // RL8
      && !((sleep_mode_in == ccr_pkg::CCR_STANDBY) && !q.control[ccr_pkg::CTL_RUN_STBY_BIT]); // RL6
    state_now = sync_level ^ q.input_select[ccr_pkg::SEL_INVERT_BIT]; // RL13
    rise = state_now && !q.state; // RL19
    fall = !state_now && q.state; // RL19
    edge_hit = 1'b0;
    if (running && clk_live) begin
      unique case (edge_mode)
        ccr_pkg::EDGE_ANY: edge_hit = rise || fall; // RL4
        ccr_pkg::EDGE_RESERVED: edge_hit = 1'b0; // RL19
        ccr_pkg::EDGE_FALLING: edge_hit = fall; // RL4
        ccr_pkg::EDGE_RISING: edge_hit = rise; // RL4
      endcase
    end
    flag_clear = reg_wr_in && (reg_addr_in == ccr_pkg::OFS_STATUS)
      && reg_wdata_in[ccr_pkg::STS_FLAG_BIT]; // RL3

    // register writes; reserved offsets fall through untouched
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ccr_pkg::OFS_CONTROL: next_q.control = reg_wdata_in;
        ccr_pkg::OFS_INPUT_SELECT: next_q.input_select = reg_wdata_in & ccr_pkg::SEL_WRITE_MASK; // RL20
        ccr_pkg::OFS_REFERENCE: next_q.reference_level = reg_wdata_in; // RL16
        ccr_pkg::OFS_INT_ENABLE: begin
          next_q.interrupt_enable = 8'h00;
          next_q.interrupt_enable[ccr_pkg::IEN_IRQ_BIT] = reg_wdata_in[ccr_pkg::IEN_IRQ_BIT]; // RL17 RL20
        end
        default: next_q.control = q.control; // RL20
      endcase
    end

    // the state bit tracks the comparator even while disabled so enabling raises no false edge
    if (clk_live) begin
      next_q.state = state_now; // RL18
      next_q.flag = (q.flag && !flag_clear) || edge_hit; // RL1 RL3
    end else begin
      next_q.state = q.state; // RL7
      next_q.flag = q.flag; // RL7
    end
    next_q.irq = next_q.interrupt_enable[ccr_pkg::IEN_IRQ_BIT] && next_q.flag; // RL2 RL17

    // event and pad follow the live level, also in standby when kept running
    next_q.core_enable = running; // RL6 RL8 RL9
    next_q.event_level = running && state_now; // RL6 RL13
    next_q.pad_oe = running && q.control[ccr_pkg::CTL_PAD_EN_BIT]; // RL8 RL10
    next_q.pad = running && q.control[ccr_pkg::CTL_PAD_EN_BIT] && state_now; // RL10 RL13

    // read data stand only in the cycle after the read strobe
    next_q.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ccr_pkg::OFS_CONTROL: next_q.rdata = q.control;
        ccr_pkg::OFS_INPUT_SELECT: next_q.rdata = q.input_select;
        ccr_pkg::OFS_REFERENCE: next_q.rdata = q.reference_level;
        ccr_pkg::OFS_INT_ENABLE: next_q.rdata = q.interrupt_enable;
        ccr_pkg::OFS_STATUS: begin
          next_q.rdata[ccr_pkg::STS_FLAG_BIT] = q.flag;
          next_q.rdata[ccr_pkg::STS_STATE_BIT] = q.state; // RL18
        end
        default: next_q.rdata = 8'h00; // RL20
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.control <= ccr_pkg::RST_CONTROL;
      q.input_select <= ccr_pkg::RST_INPUT_SELECT;
      q.reference_level <= ccr_pkg::RST_REFERENCE; // RL16
      q.interrupt_enable <= ccr_pkg::RST_INT_ENABLE;
    end else begin
      q <= next_q;
    end
  end

  // analog settings come straight from the register flops
  assign neg_sel = q.input_select[ccr_pkg::SEL_NEG_LSB +: 2];
  assign reg_rdata_out = q.rdata;
  assign core_enable_out = q.core_enable;
  assign hysteresis_select_out = q.control[ccr_pkg::CTL_HYST_LSB +: 2]; // RL11
  assign low_power_setting_out = q.control[ccr_pkg::CTL_LOW_POWER_BIT]; // RL12
  assign positive_input_select_out = q.input_select[ccr_pkg::SEL_POS_LSB +: 2]; // RL14
  assign negative_input_select_out = neg_sel; // RL15
  assign reference_select_out = q.input_select[ccr_pkg::SEL_NEG_LSB + 1] && q.input_select[ccr_pkg::SEL_NEG_LSB]; // RL15
  assign reference_level_value_out = q.reference_level; // RL16
  assign irq_out = q.irq;
  assign event_out = q.event_level;
  assign pad_out = q.pad;
  assign pad_oe_out = q.pad_oe;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence seq_edge_taken;
    edge_hit ##1 q.flag;
  endsequence

  sequence seq_clear_write;
    flag_clear && !edge_hit && clk_live;
  endsequence

  chk_edge_sets_flag: assert property (edge_hit |-> seq_edge_taken) // RL1
    else $error("selected edge did not set the flag");

  chk_flag_has_cause: assert property ($rose(q.flag) |-> $past(edge_hit)) // RL1
    else $error("flag rose without a selected edge");

  chk_edge_mode_kind: assert property (edge_hit |-> ((edge_mode == ccr_pkg::EDGE_ANY) // RL4
      || (edge_mode == ccr_pkg::EDGE_RISING && rise) || (edge_mode == ccr_pkg::EDGE_FALLING && fall)))
    else $error("edge of wrong kind was taken");

  chk_reserved_mode_quiet: assert property ((edge_mode == ccr_pkg::EDGE_RESERVED) |-> !edge_hit) // RL19
    else $error("reserved edge mode produced an interrupt");

  chk_irq_follows_flag: assert property ((q.flag && q.interrupt_enable[0]) == q.irq) // RL2
    else $error("interrupt request does not match enable and flag");

  chk_clear_one_works: assert property (seq_clear_write |=> !q.flag) // RL3
    else $error("writing one did not clear the flag");

  chk_write_zero_keeps: assert property ((reg_wr_in && reg_addr_in == ccr_pkg::OFS_STATUS // RL3
      && !reg_wdata_in[0] && q.flag) |=> q.flag)
    else $error("writing zero changed the flag");

  chk_standby_freeze: assert property ((sleep_mode_in == ccr_pkg::CCR_STANDBY) |=> $stable(q.flag) // RL7
      && $stable(q.state))
    else $error("flag or state changed with the clock stopped");

  chk_power_down_off: assert property ((sleep_mode_in == ccr_pkg::CCR_POWER_DOWN) |=> // RL8
      (!core_enable_out && !pad_oe_out && !event_out))
    else $error("comparator or pad active in power-down");

  chk_state_delay: assert property ((clk_live && $past(clk_live) && $past(clk_live, 2) // RL18
      && $stable(q.input_select[7])) |-> q.state == ($past(comparator_raw_in, 3) ^ q.input_select[7]))
    else $error("state bit is not the three-cycle synchronized output");

  chk_read_status: assert property ((reg_rd_in && reg_addr_in == ccr_pkg::OFS_STATUS) |=> // RL18 RL20
      reg_rdata_out == {3'h0, $past(q.state), 3'h0, $past(q.flag)})
    else $error("status read returned wrong data");

endmodule : ccr_comparator_control
`default_nettype wire

// ### dv/ccr_analog_model.sv
// behavioural analog comparator core with its input multiplexers and reference divider
`timescale 1ns/100ps
`default_nettype none
module ccr_analog_model (
  input wire logic core_enable_in,
  input wire logic [1:0] pos_sel_in,
  input wire logic [1:0] neg_sel_in,
  input wire logic [7:0] ref_level_in,
  input wire logic [31:0] pos_pins_in,
  input wire logic [23:0] neg_pins_in,
  output logic raw_out
);
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  // pin levels are given in steps of the reference voltage over 256
  assign pos_v = pos_pins_in[pos_sel_in*8 +: 8];
  assign neg_v = (neg_sel_in == 2'h3) ? ref_level_in : neg_pins_in[neg_sel_in*8 +: 8];
  // a switched-off core holds its output low, so enabling may itself give a real edge
  assign raw_out = core_enable_in && (pos_v > neg_v);
endmodule : ccr_analog_model
`default_nettype wire

// ### dv/ccr_comparator_control_tb_top.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module ccr_comparator_control_tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  ccr_pkg::ccr_sleep_e sleep = ccr_pkg::CCR_ACTIVE;
  logic raw, core_en, low_pwr, ref_sel, irq, evt, pad, pad_oe;
  logic [1:0] hys, pos_sel, neg_sel;
  logic [7:0] ref_lvl;
  logic [7:0] st;
  logic [31:0] pos_pins = 32'h0000_0000;
  logic [23:0] neg_pins = 24'h80_80_80;
  int err_total = 0;
  int n_tests = 0;

  always #20 clk_in = ~clk_in;

  ccr_comparator_control dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .sleep_mode_in(sleep), .comparator_raw_in(raw), .core_enable_out(core_en),
    .hysteresis_select_out(hys), .low_power_setting_out(low_pwr), .positive_input_select_out(pos_sel),
    .negative_input_select_out(neg_sel), .reference_select_out(ref_sel),
    .reference_level_value_out(ref_lvl), .irq_out(irq), .event_out(evt), .pad_out(pad),
    .pad_oe_out(pad_oe));

  ccr_analog_model model_u (.core_enable_in(core_en), .pos_sel_in(pos_sel), .neg_sel_in(neg_sel),
    .ref_level_in(ref_lvl), .pos_pins_in(pos_pins), .neg_pins_in(neg_pins), .raw_out(raw));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    chk(rdata, exp);
  endtask : rd

  // raw change reaches flag and irq three edges later, so eight edges leave margin
  task automatic setp(input logic [7:0] v);
    @(posedge clk_in);
    pos_pins[7:0] <= v;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
  endtask : setp

  task automatic go(input ccr_pkg::ccr_sleep_e s);
    @(posedge clk_in);
    sleep <= s;
  endtask : go

  initial begin : watchdog
    repeat (20000) @(posedge clk_in);
    err_total++;
    finish_test();
  end

  initial begin : main_seq
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], (a == 4) ? 8'hFF : 8'h00);
    chk(ref_lvl, 8'hFF);
    $display("test done: reset values");
    wr(3'h0, 8'h0E);
    wr(3'h2, 8'hFF);
    wr(3'h4, 8'h5A);
    wr(3'h6, 8'hFF);
    wr(3'h1, 8'hFF);
    rd(3'h0, 8'h0E);
    rd(3'h2, 8'h9B);
    rd(3'h4, 8'h5A);
    rd(3'h6, 8'h01);
    rd(3'h1, 8'h00);
    chk({core_en, low_pwr, hys, pos_sel, neg_sel}, 8'h7F);
    chk({ref_sel, ref_lvl[6:0]}, 8'hDA);
    $display("test done: register fields");
    wr(3'h2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, 8'h01 | 8'(i << 4));
      setp(8'h00);
      wr(3'h7, 8'h01);
      setp(8'hFF);
      st = {7'h08, (i == 0 || i == 3)};
      rd(3'h7, st);
      chk({7'h00, irq}, {7'h00, st[0]});
      wr(3'h7, 8'h00);
      rd(3'h7, st);
      wr(3'h7, 8'h01);
      setp(8'h00);
      rd(3'h7, {7'h00, (i == 0 || i == 2)});
    end
    $display("test done: edge modes");
    wr(3'h0, 8'h41);
    wr(3'h2, 8'h80);
    setp(8'hFF);
    chk({pad_oe, pad, evt}, 8'h04);
    rd(3'h7, 8'h01);
    wr(3'h2, 8'h00);
    setp(8'hFF);
    chk({pad_oe, pad, evt}, 8'h07);
    wr(3'h7, 8'h01);
    go(ccr_pkg::CCR_IDLE);
    setp(8'h00);
    rd(3'h7, 8'h01);
    wr(3'h7, 8'h01);
    go(ccr_pkg::CCR_STANDBY);
    setp(8'hFF);
    chk({irq, core_en, pad_oe}, 8'h00);
    go(ccr_pkg::CCR_ACTIVE);
    setp(8'h00);
    rd(3'h7, 8'h00);
    wr(3'h0, 8'hC1);
    go(ccr_pkg::CCR_STANDBY);
    setp(8'hFF);
    chk({irq, core_en, pad_oe}, 8'h03);
    go(ccr_pkg::CCR_ACTIVE);
    setp(8'hFF);
    rd(3'h7, 8'h11);
    go(ccr_pkg::CCR_POWER_DOWN);
    setp(8'hFF);
    chk({core_en, pad_oe}, 8'h00);
    go(ccr_pkg::CCR_ACTIVE);
    wr(3'h0, 8'h40);
    setp(8'hFF);
    chk({core_en, pad_oe}, 8'h00);
    $display("test done: pad, invert and sleep");
    finish_test();
  end
endmodule : ccr_comparator_control_tb_top
`default_nettype wire
